// ==== hw/azdtc_pkg.sv ====
// Shared constants for the angle zero, direction and trim configuration block.
package azdtc_pkg;
	localparam int ANGLE_W = 16;
	localparam int TRIM_W = 8;
	localparam int CYCLE_W = 16;
	localparam int CHG_W = 8;
	localparam int REFA_W = 8;
	localparam int FIELD_W = 3;
	localparam int CHANGE_PIN_HYSTERESIS_W = 6;
	localparam int FW_W = 4;
	localparam logic [15:0] ZERO_RST = 16'h0000;
	localparam logic [7:0] TRIM_RST = 8'h00;
	localparam logic [15:0] CYCLE_RST = 16'h006E;
	localparam logic [2:0] FLOW_RST = 3'h0;
	localparam logic [2:0] FHIGH_RST = 3'h7;
	localparam logic FDET_RST = 1'b1;
	localparam logic [7:0] CHG_RST = 8'h00;
	localparam logic [5:0] CHANGE_PIN_HYSTERESIS_RST = 6'h00;
	localparam logic [7:0] REFA_RST = 8'h00;
	localparam logic ASC_RST = 1'b1;
	localparam logic AUTO_SAMPLING_BY_REGISTER_RST = 1'b1;
	localparam logic [3:0] FW_RST = 4'h9;
	typedef enum logic [1:0] {
		AZDTC_TRIM_NONE = 2'h0,
		AZDTC_TRIM_X = 2'h1,
		AZDTC_TRIM_Y = 2'h2,
		AZDTC_TRIM_BOTH = 2'h3
	} azdtc_trim_mode_t;
endpackage : azdtc_pkg

// ==== hw/azdtc_sync2.sv ====
// Two flip-flop synchroniser for a single pin level.
`timescale 1ns/1ps
module azdtc_sync2 (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Level in and out.
	input wire logic pinIn,
	output logic pinOut
);
	logic stage1;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stage1 <= 1'b0;
			pinOut <= 1'b0;
		end else begin
			stage1 <= pinIn;
			pinOut <= stage1;
		end
	end
endmodule : azdtc_sync2

// ==== hw/azdtc_angle_corr.sv ====
// Zero subtraction and direction correction of the raw angle.
`timescale 1ns/1ps
module azdtc_angle_corr (
	// Inputs.
	input wire logic [azdtc_pkg::ANGLE_W-1:0] rawAngle,
	input wire logic [azdtc_pkg::ANGLE_W-1:0] zeroPosition,
	input wire logic directionCcw,
	// Result.
	output logic [azdtc_pkg::ANGLE_W-1:0] corrAngle
);
	import azdtc_pkg::*;
	logic [ANGLE_W-1:0] zeroed;
	assign zeroed = ANGLE_W'(rawAngle - zeroPosition);
	assign corrAngle = directionCcw ? ANGLE_W'(~zeroed + 16'h0001) : zeroed;
endmodule : azdtc_angle_corr

// ==== hw/azdtc_config.sv ====
// Configuration store and angle output correction for the angle sensor.
// What this block does
// - Output angle is raw minus zero position, negated when direction is set.
// - Zero position is unsigned sixteen-bit code.
// - Direction clear: clockwise rotation increases angle.
// - Direction set: counterclockwise rotation increases angle.
// - Hold eight-bit bias trim amount.
// - Per-axis trim enables for X and Y.
// - Both enables give equal reduction, no correction.
// - Trim amount defaults to zero.
// - Hold cycle time, change threshold, reference angle.
// - Auto-refresh replaces reference on each change while auto sampling is active.
// - Change pin latch select and hysteresis.
// - Auto sampling enable and register-driven permit.
// - Field detect enable and two thresholds.
// - Four-bit filter window size.
`timescale 1ns/1ps
module azdtc_config
	import azdtc_pkg::*;
(
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Raw angle from the front end.
	input wire logic [azdtc_pkg::ANGLE_W-1:0] rawAngle,
	input wire logic rawValid,
	// Configuration writes.
	input wire logic [azdtc_pkg::ANGLE_W-1:0] zeroPositionIn,
	input wire logic zeroPositionWr,
	input wire logic directionIn,
	input wire logic directionWr,
	input wire logic [azdtc_pkg::TRIM_W-1:0] biasTrimAmountIn,
	input wire logic biasTrimAmountWr,
	input wire logic trimEnableXAxisIn,
	input wire logic trimEnableYAxisIn,
	input wire logic trimEnableWr,
	input wire logic [azdtc_pkg::CYCLE_W-1:0] samplingCycleTimeIn,
	input wire logic samplingCycleTimeWr,
	input wire logic [azdtc_pkg::FIELD_W-1:0] fieldLowThresholdIn,
	input wire logic [azdtc_pkg::FIELD_W-1:0] fieldHighThresholdIn,
	input wire logic fieldDetectEnableIn,
	input wire logic fieldConfigWr,
	input wire logic [azdtc_pkg::CHG_W-1:0] changeThresholdIn,
	input wire logic changeThresholdWr,
	input wire logic changePinLatchSelectIn,
	input wire logic referenceAutoRefreshIn,
	input wire logic [azdtc_pkg::CHANGE_PIN_HYSTERESIS_W-1:0] changePinHysteresisIn,
	input wire logic changePinConfigWr,
	input wire logic [azdtc_pkg::REFA_W-1:0] referenceAngleIn,
	input wire logic referenceAngleWr,
	input wire logic autoSamplingEnableIn,
	input wire logic autoSamplingByRegisterIn,
	input wire logic autoSamplingWr,
	input wire logic [azdtc_pkg::FW_W-1:0] filterWindowSizeIn,
	input wire logic filterWindowSizeWr,
	// Change detection from the sampling logic and external control pin.
	input wire logic changeDetected,
	input wire logic autoSamplingPin,
	// Corrected angle.
	output logic [azdtc_pkg::ANGLE_W-1:0] outAngle,
	output logic outAngleValid,
	// Trim settings to the front end.
	output logic [azdtc_pkg::TRIM_W-1:0] biasTrimAmount,
	output logic trimEnableXAxis,
	output logic trimEnableYAxis,
	output logic trimBothAxes,
	// Sampling and detection settings.
	output logic [azdtc_pkg::CYCLE_W-1:0] samplingCycleTime,
	output logic [azdtc_pkg::CHG_W-1:0] changeThreshold,
	output logic [azdtc_pkg::REFA_W-1:0] referenceAngle,
	output logic referenceAutoRefresh,
	output logic changePinLatchSelect,
	output logic [azdtc_pkg::CHANGE_PIN_HYSTERESIS_W-1:0] changePinHysteresis,
	output logic autoSamplingEnable,
	output logic autoSamplingByRegister,
	output logic autoSamplingActive,
	output logic fieldDetectEnable,
	output logic [azdtc_pkg::FIELD_W-1:0] fieldLowThreshold,
	output logic [azdtc_pkg::FIELD_W-1:0] fieldHighThreshold,
	output logic [azdtc_pkg::FW_W-1:0] filterWindowSize,
	output logic directionCcw,
	output logic [azdtc_pkg::ANGLE_W-1:0] zeroPosition
);
	import azdtc_pkg::*;

	logic [ANGLE_W-1:0] next_outAngle;
	logic ascPinSync;
	azdtc_trim_mode_t trimMode;

	azdtc_sync2 u_ascSync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pinIn(autoSamplingPin),
		.pinOut(ascPinSync)
	);

	azdtc_angle_corr u_corr (
		.rawAngle(rawAngle),
		.zeroPosition(zeroPosition),
		.directionCcw(directionCcw),
		.corrAngle(next_outAngle)
	);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			zeroPosition <= ZERO_RST;
		end else if (zeroPositionWr) begin
			zeroPosition <= zeroPositionIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			directionCcw <= 1'b0;
		end else if (directionWr) begin
			directionCcw <= directionIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			outAngle <= ZERO_RST;
			outAngleValid <= 1'b0;
		end else begin
			outAngleValid <= rawValid;
			if (rawValid) begin
				outAngle <= next_outAngle;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			biasTrimAmount <= TRIM_RST;
		end else if (biasTrimAmountWr) begin
			biasTrimAmount <= biasTrimAmountIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trimEnableXAxis <= 1'b0;
			trimEnableYAxis <= 1'b0;
		end else if (trimEnableWr) begin
			trimEnableXAxis <= trimEnableXAxisIn;
			trimEnableYAxis <= trimEnableYAxisIn;
		end
	end

	assign trimMode = azdtc_trim_mode_t'({trimEnableYAxis, trimEnableXAxis});

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trimBothAxes <= 1'b0;
		end else begin
			trimBothAxes <= (trimMode == AZDTC_TRIM_BOTH);
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			samplingCycleTime <= CYCLE_RST;
			changeThreshold <= CHG_RST;
		end else begin
			if (samplingCycleTimeWr) begin
				samplingCycleTime <= samplingCycleTimeIn;
			end
			if (changeThresholdWr) begin
				changeThreshold <= changeThresholdIn;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			referenceAngle <= REFA_RST;
		end else if (autoSamplingActive && referenceAutoRefresh && changeDetected) begin
			referenceAngle <= outAngle[ANGLE_W-1 -: REFA_W];
		end else if (referenceAngleWr) begin
			referenceAngle <= referenceAngleIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			changePinLatchSelect <= 1'b0;
			referenceAutoRefresh <= 1'b0;
			changePinHysteresis <= CHANGE_PIN_HYSTERESIS_RST;
		end else if (changePinConfigWr) begin
			changePinLatchSelect <= changePinLatchSelectIn;
			referenceAutoRefresh <= referenceAutoRefreshIn;
			changePinHysteresis <= changePinHysteresisIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			autoSamplingEnable <= ASC_RST;
			autoSamplingByRegister <= AUTO_SAMPLING_BY_REGISTER_RST;
		end else if (autoSamplingWr) begin
			autoSamplingEnable <= autoSamplingEnableIn;
			autoSamplingByRegister <= autoSamplingByRegisterIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			autoSamplingActive <= 1'b0;
		end else if (autoSamplingByRegister) begin
			autoSamplingActive <= autoSamplingEnable;
		end else begin
			autoSamplingActive <= ascPinSync;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fieldDetectEnable <= FDET_RST;
			fieldLowThreshold <= FLOW_RST;
			fieldHighThreshold <= FHIGH_RST;
		end else if (fieldConfigWr) begin
			fieldDetectEnable <= fieldDetectEnableIn;
			fieldLowThreshold <= fieldLowThresholdIn;
			fieldHighThreshold <= fieldHighThresholdIn;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			filterWindowSize <= FW_RST;
		end else if (filterWindowSizeWr) begin
			filterWindowSize <= filterWindowSizeIn;
		end
	end

	AST_ZERO_SUB: assert property (@(posedge clock) disable iff (sys_rst)
		(rawValid && !directionCcw && !zeroPositionWr && !directionWr) |=>
		outAngle == ANGLE_W'($past(rawAngle) - zeroPosition))
		else $error("Angle is not raw minus zero.");

	AST_DIR_NEG: assert property (@(posedge clock) disable iff (sys_rst)
		(rawValid && directionCcw && !zeroPositionWr && !directionWr) |=>
		ANGLE_W'(outAngle + ANGLE_W'($past(rawAngle) - zeroPosition)) == 16'h0000)
		else $error("Reversed angle is not negated.");

	AST_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
		(rawValid && !directionCcw && rawAngle < zeroPosition && !zeroPositionWr
		&& !directionWr) |=> outAngle > $past(rawAngle))
		else $error("Subtraction did not wrap.");

	AST_TRIM_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		!biasTrimAmountWr |=> $stable(biasTrimAmount))
		else $error("Trim amount changed without a write.");

	AST_TRIM_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
		biasTrimAmountWr |=> biasTrimAmount == $past(biasTrimAmountIn))
		else $error("Trim amount not loaded.");

	AST_BOTH: assert property (@(posedge clock) disable iff (sys_rst)
		(trimEnableWr && trimEnableXAxisIn && trimEnableYAxisIn) |=> ##1 trimBothAxes)
		else $error("Both-axes flag missing.");

	AST_REFRESH: assert property (@(posedge clock) disable iff (sys_rst)
		(autoSamplingActive && referenceAutoRefresh && changeDetected) |=>
		referenceAngle == $past(outAngle[ANGLE_W-1 -: REFA_W]))
		else $error("Reference not refreshed.");

	AST_ASC_REG: assert property (@(posedge clock) disable iff (sys_rst)
		(autoSamplingByRegister && !autoSamplingWr) [*2] |-> autoSamplingActive == autoSamplingEnable)
		else $error("Register-driven mode not followed.");

	AST_FW_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
		!filterWindowSizeWr |=> $stable(filterWindowSize))
		else $error("Filter window changed without a write.");

	AST_AXIS_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
		trimEnableWr |=> (trimEnableXAxis == $past(trimEnableXAxisIn))
		&& (trimEnableYAxis == $past(trimEnableYAxisIn)))
		else $error("Axis trim enables not loaded.");

	AST_ASC_PIN: assert property (@(posedge clock) disable iff (sys_rst)
		!autoSamplingByRegister |=> autoSamplingActive == $past(ascPinSync))
		else $error("Pin-driven mode not followed.");

endmodule : azdtc_config

// ==== tb/azdtc_front_model.sv ====
// Front-end model that supplies raw angle samples to the configuration block.
`timescale 1ns/1ps
module azdtc_front_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic sys_rst,
	// Commands from the bench.
	input wire logic load,
	input wire logic [15:0] loadAngle,
	input wire logic stepCw,
	input wire logic stepCcw,
	// Raw samples to the block.
	output logic [15:0] rawAngle,
	output logic rawValid
);
	logic [15:0] angle;
	// Outside a valid cycle the bus shows the inverse, so a stale value is never trusted.
	assign rawAngle = rawValid ? angle : ~angle;
	// Clockwise field rotation raises the raw angle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			angle <= 16'h0000;
			rawValid <= 1'b0;
		end else begin
			rawValid <= load | stepCw | stepCcw;
			if (load) begin
				angle <= loadAngle;
			end else if (stepCw) begin
				angle <= angle + 16'h0010;
			end else if (stepCcw) begin
				angle <= angle - 16'h0010;
			end
		end
	end
endmodule : azdtc_front_model

// ==== tb/tb.sv ====
// Self-checking bench for the angle configuration block.
`timescale 1ns/1ps
module tb;
	import azdtc_pkg::*;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [10:0] wr = '0;
	logic [2:0] cmd = '0;
	logic [15:0] zeroPositionIn = '0, samplingCycleTimeIn = '0, loadAngle = '0;
	logic [7:0] biasTrimAmountIn = '0, changeThresholdIn = '0, referenceAngleIn = '0;
	logic [5:0] changePinHysteresisIn = '0;
	logic [3:0] filterWindowSizeIn = '0;
	logic [2:0] fieldLowThresholdIn = '0, fieldHighThresholdIn = '0;
	logic directionIn = 1'b0, trimEnableXAxisIn = 1'b0, trimEnableYAxisIn = 1'b0;
	logic fieldDetectEnableIn = 1'b0, changePinLatchSelectIn = 1'b0;
	logic referenceAutoRefreshIn = 1'b0, autoSamplingEnableIn = 1'b0;
	logic autoSamplingByRegisterIn = 1'b0, changeDetected = 1'b0, autoSamplingPin = 1'b0;
	logic [15:0] rawAngle, outAngle, samplingCycleTime, zeroPosition;
	logic [7:0] biasTrimAmount, changeThreshold, referenceAngle;
	logic [5:0] changePinHysteresis;
	logic [3:0] filterWindowSize;
	logic [2:0] fieldLowThreshold, fieldHighThreshold;
	logic rawValid, outAngleValid, trimEnableXAxis, trimEnableYAxis, trimBothAxes;
	logic referenceAutoRefresh, changePinLatchSelect, autoSamplingEnable;
	logic autoSamplingByRegister, autoSamplingActive, fieldDetectEnable, directionCcw;
	int errTotal = 0;
	int nCompared = 0;
	always #2 clock = ~clock;
	azdtc_front_model model (.clock, .sys_rst, .load(cmd[0]), .loadAngle,
		.stepCw(cmd[1]), .stepCcw(cmd[2]), .rawAngle, .rawValid);
	azdtc_config DUT (.clock, .sys_rst, .rawAngle, .rawValid, .zeroPositionIn,
		.zeroPositionWr(wr[0]), .directionIn, .directionWr(wr[1]), .biasTrimAmountIn,
		.biasTrimAmountWr(wr[2]), .trimEnableXAxisIn, .trimEnableYAxisIn,
		.trimEnableWr(wr[3]), .samplingCycleTimeIn, .samplingCycleTimeWr(wr[4]),
		.fieldLowThresholdIn, .fieldHighThresholdIn, .fieldDetectEnableIn,
		.fieldConfigWr(wr[5]), .changeThresholdIn, .changeThresholdWr(wr[6]),
		.changePinLatchSelectIn, .referenceAutoRefreshIn, .changePinHysteresisIn,
		.changePinConfigWr(wr[7]), .referenceAngleIn, .referenceAngleWr(wr[8]),
		.autoSamplingEnableIn, .autoSamplingByRegisterIn, .autoSamplingWr(wr[9]),
		.filterWindowSizeIn, .filterWindowSizeWr(wr[10]), .changeDetected,
		.autoSamplingPin, .outAngle, .outAngleValid, .biasTrimAmount, .trimEnableXAxis,
		.trimEnableYAxis, .trimBothAxes, .samplingCycleTime, .changeThreshold,
		.referenceAngle, .referenceAutoRefresh, .changePinLatchSelect,
		.changePinHysteresis, .autoSamplingEnable, .autoSamplingByRegister,
		.autoSamplingActive, .fieldDetectEnable, .fieldLowThreshold, .fieldHighThreshold,
		.filterWindowSize, .directionCcw, .zeroPosition);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		nCompared++;
		if (got !== exp) begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrPulse(input int idx);
		@(negedge clock);
		wr[idx] = 1'b1;
		@(negedge clock);
		wr = '0;
	endtask : wrPulse
	task automatic sample(input int kind, input logic [15:0] v, input logic [15:0] exp);
		@(negedge clock);
		cmd[kind] = 1'b1;
		loadAngle = v;
		@(negedge clock);
		cmd = '0;
		@(negedge clock);
		chk("outAngleValid", 16'h0001, 16'(outAngleValid));
		chk("outAngle", exp, outAngle);
	endtask : sample
	task automatic pulseChange;
		@(negedge clock);
		changeDetected = 1'b1;
		@(negedge clock);
		changeDetected = 1'b0;
		@(negedge clock);
	endtask : pulseChange
	task automatic wrap_up;
		$display("compared %0d mismatches %0d", nCompared, errTotal);
		if (errTotal == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (1000) @(posedge clock);
		errTotal++;
		wrap_up();
	end
	initial begin
		repeat (5) @(negedge clock);
		sys_rst = 1'b0;
		repeat (2) @(negedge clock);
		chk("zero", ZERO_RST, zeroPosition);
		chk("trim", 16'(TRIM_RST), 16'(biasTrimAmount));
		chk("dir", 16'h0000, 16'(directionCcw));
		chk("cycle", CYCLE_RST, samplingCycleTime);
		chk("fw", 16'(FW_RST), 16'(filterWindowSize));
		chk("fhigh", 16'(FHIGH_RST), 16'(fieldHighThreshold));
		chk("active", 16'(ASC_RST), 16'(autoSamplingActive));
		zeroPositionIn = 16'hFFFF;
		wrPulse(0);
		chk("zero", 16'hFFFF, zeroPosition);
		sample(0, 16'h0000, 16'h0001);
		zeroPositionIn = 16'h1000;
		wrPulse(0);
		sample(0, 16'h1800, 16'h0800);
		sample(1, 16'h0000, 16'h0810);
		directionIn = 1'b1;
		wrPulse(1);
		sample(1, 16'h0000, 16'hF7E0);
		sample(2, 16'h0000, 16'hF7F0);
		biasTrimAmountIn = 8'(258 - 258 / 2);
		wrPulse(2);
		chk("trim", 16'h0081, 16'(biasTrimAmount));
		biasTrimAmountIn = 8'hFF;
		wrPulse(2);
		chk("trim", 16'h00FF, 16'(biasTrimAmount));
		trimEnableXAxisIn = 1'b1;
		wrPulse(3);
		@(negedge clock);
		chk("xy", 16'h0002, {14'h0000, trimEnableXAxis, trimEnableYAxis});
		chk("both", 16'h0000, 16'(trimBothAxes));
		trimEnableYAxisIn = 1'b1;
		wrPulse(3);
		@(negedge clock);
		chk("both", 16'h0001, 16'(trimBothAxes));
		samplingCycleTimeIn = 16'hFFFF;
		changeThresholdIn = 8'hA5;
		fieldLowThresholdIn = 3'h7;
		filterWindowSizeIn = 4'hF;
		changePinHysteresisIn = 6'h2A;
		changePinLatchSelectIn = 1'b1;
		referenceAutoRefreshIn = 1'b1;
		wrPulse(4);
		wrPulse(5);
		wrPulse(6);
		wrPulse(7);
		wrPulse(10);
		chk("cycle", 16'hFFFF, samplingCycleTime);
		chk("thr", 16'h00A5, 16'(changeThreshold));
		chk("field", 16'h0038, {9'h000, fieldDetectEnable, fieldLowThreshold,
			fieldHighThreshold});
		chk("pin", 16'h00EA, {8'h00, changePinLatchSelect, referenceAutoRefresh,
			changePinHysteresis});
		chk("fw", 16'h000F, 16'(filterWindowSize));
		referenceAngleIn = 8'h5A;
		wrPulse(8);
		chk("ref", 16'h005A, 16'(referenceAngle));
		pulseChange();
		chk("ref", 16'h00F7, 16'(referenceAngle));
		wrPulse(9);
		@(negedge clock);
		chk("active", 16'h0000, 16'(autoSamplingActive));
		referenceAngleIn = 8'h11;
		wrPulse(8);
		pulseChange();
		chk("ref", 16'h0011, 16'(referenceAngle));
		autoSamplingPin = 1'b1;
		repeat (4) @(negedge clock);
		chk("active", 16'h0001, 16'(autoSamplingActive));
		autoSamplingByRegisterIn = 1'b1;
		wrPulse(9);
		@(negedge clock);
		chk("active", 16'h0000, 16'(autoSamplingActive));
		chk("asc", 16'h0001, {14'h0000, autoSamplingEnable, autoSamplingByRegister});
		wrap_up();
	end
endmodule : tb
